/* src/scld_pkg.sv */
// Purpose: shared constants and types for the synthesizer configuration block
// Assumes: 24-bit serial words, two lowest bits select the target register
// Notes:   field positions are bit indices within the received word
`default_nettype none

package scld_pkg;

  typedef logic [23:0] scld_word_t;

  // register select codes in word bits 1:0
  localparam logic [1:0] SEL_INT   = 2'h0;
  localparam logic [1:0] SEL_REF   = 2'h1;
  localparam logic [1:0] SEL_CTRL  = 2'h2;
  localparam logic [1:0] SEL_NOISE = 2'h3;

  // reference and modulus word
  localparam int LOAD_CTRL_BIT = 23;
  localparam int MUX_HI        = 22;
  localparam int MUX_LO        = 20;
  localparam int PRESCALER_BIT = 18;
  localparam int RDIV_HI       = 17;
  localparam int RDIV_LO       = 14;
  localparam int MODF_HI       = 13;
  localparam int MODF_LO       = 2;

  // integer and fraction word
  localparam int FASTLOCK_BIT  = 23;
  localparam int INT_HI        = 22;
  localparam int INT_LO        = 14;
  localparam int FRACTION_VALUE_HI       = 13;
  localparam int FRACTION_VALUE_LO       = 2;

  // control word
  localparam int CNT_RST_BIT   = 2;
  localparam int CP_TRI_BIT    = 3;
  localparam int PD_BIT        = 4;
  localparam int LDP_BIT       = 5;
  localparam int POL_BIT       = 6;
  localparam int CPI_HI        = 10;
  localparam int CPI_LO        = 7;
  localparam int DBL_BIT       = 11;

  // noise and spur word
  localparam int NS_DITHER_OFF_BIT = 2;
  localparam int NS_BIAS_HI        = 9;
  localparam int NS_BIAS_LO        = 6;
  localparam logic [3:0] NS_BIAS_ALL = 4'hf;

  // lock detect run lengths
  localparam logic [5:0] LOCK_RUN_LOW  = 6'h18;
  localparam logic [5:0] LOCK_RUN_HIGH = 6'h28;

  // multiplexed output codes
  localparam logic [2:0] MUX_TRISTATE = 3'h0;
  localparam logic [2:0] MUX_DIG_LOCK = 3'h1;
  localparam logic [2:0] MUX_N_DIV    = 3'h2;
  localparam logic [2:0] MUX_HIGH     = 3'h3;
  localparam logic [2:0] MUX_R_DIV    = 3'h4;
  localparam logic [2:0] MUX_OD_LOCK  = 3'h5;
  localparam logic [2:0] MUX_FL_SW    = 3'h6;
  localparam logic [2:0] MUX_LOW      = 3'h7;

  // values after reset
  localparam scld_word_t  RST_WORD   = 24'h000000;
  localparam logic [11:0] RST_FIELD  = 12'h000;
  localparam logic [3:0]  REF_DIV_MIN = 4'h1;

  typedef enum logic {FL_NARROW = 1'b0, FL_WIDE = 1'b1} scld_fl_state_t;
  typedef enum logic {LD_SEEK = 1'b0, LD_HELD = 1'b1} scld_ld_state_t;

endpackage : scld_pkg

`default_nettype wire

/* src/scld_if.sv */
// Purpose: carries a received configuration word into the core
// Assumes: word stays stable while the load pulse is seen
// Notes:   load is a one-cycle pulse on clk
`default_nettype none

interface scld_if;
  scld_pkg::scld_word_t word;
  logic                 load;
  modport rx   (output word, output load);
  modport core (input word, input load);
endinterface : scld_if

`default_nettype wire

/* src/scld_serial_rx.sv */
// Purpose: three-wire serial receiver, shift on link clock, load on clk
// Assumes: link clock is quiet while the load strobe is high
// Notes:   word is quasi-static across the crossing
`default_nettype none

module scld_serial_rx (
  // link side
  input  wire logic sclk,
  input  wire logic sdata,
  input  wire logic sle,
  // core side
  input  wire logic clk,
  input  wire logic rst,
  scld_if.rx        bus
);
  import scld_pkg::*;

  scld_word_t shift;
  logic       le_s1;
  logic       le_s2;
  logic       le_s3;

  // msb first shift on link clock
  always_ff @(posedge sclk) begin
    shift <= {shift[22:0], sdata};
  end

  // load strobe synchroniser and edge detect
  always_ff @(posedge clk) begin
    if (rst) begin
      le_s1 <= 1'b0;
      le_s2 <= 1'b0;
      le_s3 <= 1'b0;
    end else begin
      le_s1 <= sle;
      le_s2 <= le_s1;
      le_s3 <= le_s2;
    end
  end

  // capture word once strobe is seen
  always_ff @(posedge clk) begin
    if (rst) begin
      bus.word <= RST_WORD;
      bus.load <= 1'b0;
    end else begin
      bus.load <= le_s2 & ~le_s3;
      if (le_s2 & ~le_s3) begin
        bus.word <= shift;
      end
    end
  end

endmodule : scld_serial_rx

`default_nettype wire

/* src/scld_core.sv */
// Purpose: configuration registers, fast lock and lock detect of a synthesizer
// Assumes: comparison strobe and phase error flags come from clk logic
// Notes:   serial words arrive through the receiver on the link clock
`default_nettype none

module scld_core (
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // serial programming pins
  input  wire logic                 sclk,
  input  wire logic                 sdata,
  input  wire logic                 sle,
  // phase comparator status
  input  wire logic                 cmp_cycle,
  input  wire logic                 err_below_15,
  input  wire logic                 err_above_30,
  // divider monitor pins
  input  wire logic                 n_div_mon,
  input  wire logic                 r_div_mon,
  // synthesizer controls
  output logic                      counters_reset,
  output logic                      cp_tristate,
  output logic                      power_down,
  output logic                      phase_polarity,
  output logic [3:0]                cp_current,
  output logic                      cp_gain_16x,
  output logic                      ref_doubler,
  output logic                      ref_both_edges,
  output logic [3:0]                ref_div,
  output logic                      prescaler_89,
  output logic [8:0]                int_value,
  output logic [11:0]               fraction_value,
  output logic [11:0]               interpolator_modulus,
  output logic                      dither_en,
  output logic                      cp_low_noise_bias,
  // status and pin
  output logic                      lock_detect,
  output logic                      muxed_test_output,
  output logic                      muxed_test_output_oe_n,
  output scld_pkg::scld_fl_state_t  fl_state
);
  import scld_pkg::*;

  scld_if ser ();

  scld_serial_rx u_rx (
    .sclk (sclk),
    .sdata(sdata),
    .sle  (sle),
    .clk  (clk),
    .rst  (rst),
    .bus  (ser.rx)
  );

  scld_word_t      w;
  logic            wr_ref;
  logic            wr_ctrl;
  logic            wr_noise;
  logic            wr_int;
  logic [2:0]      mux_sel;
  logic [3:0]      ref_div_raw;
  logic [11:0]     mod_buf;
  logic [11:0]     fl_timer;
  logic [11:0]     fl_count;
  scld_word_t      ctrl_word;
  scld_word_t      noise_word;
  logic [5:0]      run_good;
  logic [5:0]      need_m1;
  scld_ld_state_t  ld_state;
  logic [1:0]      mon_s1;
  logic [1:0]      mon_s2;
  logic            next_mux_o;
  logic            next_mux_oe_n;

  assign w        = ser.word;
  assign wr_ref   = ser.load && (w[1:0] == SEL_REF);
  assign wr_ctrl  = ser.load && (w[1:0] == SEL_CTRL);
  assign wr_noise = ser.load && (w[1:0] == SEL_NOISE);
  assign wr_int   = ser.load && (w[1:0] == SEL_INT);

  // reference and modulus register
  always_ff @(posedge clk) begin
    if (rst) begin
      mux_sel     <= MUX_TRISTATE;
      prescaler_89 <= 1'b0;
      ref_div_raw <= REF_DIV_MIN;
      mod_buf     <= RST_FIELD;
      fl_timer    <= RST_FIELD;
    end else if (wr_ref) begin
      mux_sel      <= w[MUX_HI:MUX_LO];
      prescaler_89 <= w[PRESCALER_BIT];
      ref_div_raw  <= w[RDIV_HI:RDIV_LO];
      if (w[LOAD_CTRL_BIT]) begin
        fl_timer <= w[MODF_HI:MODF_LO];
      end else begin
        mod_buf <= w[MODF_HI:MODF_LO];
      end
    end
  end

  // zero is not a legal divide, run it as one
  assign ref_div = (ref_div_raw == 4'h0) ? REF_DIV_MIN : ref_div_raw;

  // integer and fraction register, commits buffered modulus
  always_ff @(posedge clk) begin
    if (rst) begin
      int_value            <= 9'h000;
      fraction_value       <= RST_FIELD;
      interpolator_modulus <= RST_FIELD;
    end else if (wr_int) begin
      int_value            <= w[INT_HI:INT_LO];
      fraction_value       <= w[FRACTION_VALUE_HI:FRACTION_VALUE_LO];
      interpolator_modulus <= mod_buf;
    end
  end

  // control register, kept through power-down
  always_ff @(posedge clk) begin
    if (rst) begin
      ctrl_word <= RST_WORD;
    end else if (wr_ctrl) begin
      ctrl_word <= w;
    end
  end

  // noise and spur register
  always_ff @(posedge clk) begin
    if (rst) begin
      noise_word <= RST_WORD;
    end else if (wr_noise) begin
      noise_word <= w;
    end
  end

  assign power_down     = ctrl_word[PD_BIT];
  assign counters_reset = ctrl_word[CNT_RST_BIT] | power_down;
  assign cp_tristate    = ctrl_word[CP_TRI_BIT] | power_down;
  assign phase_polarity = ctrl_word[POL_BIT];
  assign cp_current     = ctrl_word[CPI_HI:CPI_LO];
  assign ref_doubler    = ctrl_word[DBL_BIT];
  assign ref_both_edges = ctrl_word[DBL_BIT];

  // noise mode decode
  assign dither_en         = ~noise_word[NS_DITHER_OFF_BIT];
  assign cp_low_noise_bias = noise_word[NS_DITHER_OFF_BIT]
                             && (noise_word[NS_BIAS_HI:NS_BIAS_LO] == NS_BIAS_ALL);

  // fast-lock timer
  always_ff @(posedge clk) begin
    if (rst) begin
      fl_state <= FL_NARROW;
      fl_count <= RST_FIELD;
    end else if (power_down) begin
      fl_state <= FL_NARROW;
      fl_count <= RST_FIELD;
    end else if (wr_int && w[FASTLOCK_BIT] && (fl_timer != RST_FIELD)) begin
      fl_state <= FL_WIDE;
      fl_count <= fl_timer;
    end else begin
      unique case (fl_state)
        FL_NARROW: begin
          fl_count <= RST_FIELD;
        end
        FL_WIDE: begin
          if (cmp_cycle) begin
            fl_count <= fl_count - 12'h001;
            if (fl_count == 12'h001) begin
              fl_state <= FL_NARROW;
            end
          end
        end
      endcase
    end
  end

  assign cp_gain_16x = (fl_state == FL_WIDE);

  // lock detect
  assign need_m1 = (ctrl_word[LDP_BIT] ? LOCK_RUN_HIGH : LOCK_RUN_LOW) - 6'h01;

  always_ff @(posedge clk) begin
    if (rst) begin
      ld_state <= LD_SEEK;
      run_good <= 6'h00;
    end else if (power_down || wr_int) begin
      ld_state <= LD_SEEK;
      run_good <= 6'h00;
    end else if (cmp_cycle) begin
      if (err_above_30) begin
        ld_state <= LD_SEEK;
        run_good <= 6'h00;
      end else if (err_below_15) begin
        if (run_good >= need_m1) begin
          ld_state <= LD_HELD;
        end else begin
          run_good <= run_good + 6'h01;
        end
      end else begin
        run_good <= 6'h00;
      end
    end
  end

  assign lock_detect = (ld_state == LD_HELD);

  // divider monitor synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_mon
      always_ff @(posedge clk) begin
        if (rst) begin
          mon_s1[gi] <= 1'b0;
          mon_s2[gi] <= 1'b0;
        end else begin
          mon_s1[gi] <= (gi == 0) ? n_div_mon : r_div_mon;
          mon_s2[gi] <= mon_s1[gi];
        end
      end
    end
  endgenerate

  // output multiplexer
  always_comb begin
    next_mux_o    = 1'b0;
    next_mux_oe_n = 1'b0;
    unique case (mux_sel)
      MUX_TRISTATE: next_mux_oe_n = 1'b1;
      MUX_DIG_LOCK: next_mux_o    = lock_detect;
      MUX_N_DIV:    next_mux_o    = mon_s2[0];
      MUX_HIGH:     next_mux_o    = 1'b1;
      MUX_R_DIV:    next_mux_o    = mon_s2[1];
      MUX_OD_LOCK:  next_mux_oe_n = lock_detect;
      MUX_FL_SW:    next_mux_oe_n = (fl_state != FL_WIDE);
      MUX_LOW:      next_mux_o    = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      muxed_test_output      <= 1'b0;
      muxed_test_output_oe_n <= 1'b1;
    end else begin
      muxed_test_output      <= next_mux_o;
      muxed_test_output_oe_n <= next_mux_oe_n;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_ref_mod_write;
    wr_ref && !w[LOAD_CTRL_BIT];
  endsequence

  sequence s_ref_timer_write;
    wr_ref && w[LOAD_CTRL_BIT];
  endsequence

  sequence s_int_write;
    wr_int;
  endsequence

  chk_ref_route_mux: assert property (
    wr_ref |=> mux_sel == $past(w[MUX_HI:MUX_LO]))
    else $error("reference word not routed");

  chk_mod_buffered: assert property (
    s_ref_mod_write ##0 !wr_int |=> $stable(interpolator_modulus)
      && mod_buf == $past(w[MODF_HI:MODF_LO]))
    else $error("modulus applied before integer write");

  chk_timer_only: assert property (
    s_ref_timer_write |=> fl_timer == $past(w[MODF_HI:MODF_LO]) && $stable(mod_buf))
    else $error("timer write touched modulus");

  chk_mod_commit: assert property (
    s_int_write |=> interpolator_modulus == $past(mod_buf))
    else $error("integer write did not commit modulus");

  chk_fl_expiry: assert property (
    fl_state == FL_WIDE && cmp_cycle && fl_count == 12'h001 && !wr_int && !power_down
      |=> fl_state == FL_NARROW && !cp_gain_16x)
    else $error("fast lock did not end at timer expiry");

  chk_fl_start: assert property (
    s_int_write ##0 w[FASTLOCK_BIT] && fl_timer != RST_FIELD && !power_down
      |=> cp_gain_16x && fl_count == $past(fl_timer))
    else $error("fast lock not entered");

  chk_lock_drop: assert property (
    cmp_cycle && err_above_30 |=> !lock_detect)
    else $error("lock held through large error");

  chk_lock_run: assert property (
    !lock_detect ##1 lock_detect |-> $past(run_good) >= $past(need_m1)
      && $past(cmp_cycle && err_below_15))
    else $error("lock rose before full run");

  chk_pd_effects: assert property (
    power_down |-> counters_reset && cp_tristate ##1 !lock_detect)
    else $error("power-down side effects missing");

  chk_cnt_reset: assert property (
    wr_ctrl && w[CNT_RST_BIT] |=> counters_reset)
    else $error("counters not held");

  chk_fl_switch_pin: assert property (
    mux_sel == MUX_FL_SW && fl_state == FL_WIDE ##1 mux_sel == MUX_FL_SW
      |-> !muxed_test_output_oe_n && !muxed_test_output)
    else $error("fast-lock switch not grounded");

endmodule : scld_core

`default_nettype wire

/* test/scld_host_model.sv */
// Purpose: host model driving the three-wire serial programming pins
// Assumes: link clock period of 12 ns, clock quiet between frames
// Notes:   data line shows the inverse of its last bit once released
`default_nettype none

module scld_host_model (
  // serial pins
  output var logic sclk,
  output var logic sdata,
  output var logic sle
);
  timeunit 1ns;
  timeprecision 100ps;
  import scld_pkg::*;

  // stretches the clock high phase for a slow host
  int unsigned extra_ns;

  initial begin
    sclk     = 1'b0;
    sdata    = 1'b0;
    sle      = 1'b0;
    extra_ns = 0;
  end

  // one word, msb first, then the load strobe
  task automatic send(input scld_word_t w);
    for (int i = 23; i >= 0; i--) begin
      sdata = w[i];
      #6 sclk = 1'b1;
      #(6 + extra_ns) sclk = 1'b0;
    end
    sdata = ~sdata;
    #6 sle = 1'b1;
    #25 sle = 1'b0;
    #6;
  endtask : send
endmodule : scld_host_model

`default_nettype wire

/* test/scld_core_bench.sv */
// Purpose: self-checking bench for the configuration and lock detect block
// Assumes: host model writes words, bench drives comparator and monitor pins
// Notes:   expectations queue up, a monitor compares them at each settle
`default_nettype none

module scld_core_bench;
  timeunit 1ns;
  timeprecision 100ps;
  import scld_pkg::*;

  typedef enum int {S_CRST, S_TRI, S_PD, S_POL, S_CPI, S_G16, S_DBL, S_EDGE, S_RDIV,
    S_MOD, S_INT, S_FRACTION_VALUE, S_DITH, S_BIAS, S_LOCK, S_MUX, S_OEN, S_PRE, S_FL} scld_sig_t;
  typedef struct {scld_sig_t id; logic [11:0] exp;} scld_note_t;

  logic clk, rst, sclk, sdata, sle, cmp_cycle, err_below_15, err_above_30;
  logic n_div_mon, r_div_mon, counters_reset, cp_tristate, power_down, phase_polarity;
  logic cp_gain_16x, ref_doubler, ref_both_edges, prescaler_89, dither_en;
  logic cp_low_noise_bias, lock_detect, muxed_test_output, muxed_test_output_oe_n;
  logic [3:0]     cp_current, ref_div;
  logic [8:0]     int_value;
  logic [11:0]    fraction_value, interpolator_modulus, m1, fr;
  logic [3:0]     rd;
  logic [8:0]     iv;
  logic           pre;
  scld_fl_state_t fl_state;
  int             num_errors, tests_run;
  scld_note_t     notes[$];
  event           settle_ev;
  logic [2:0]     mux_codes [6];
  logic           mux_exp [6];

  always_comb begin
    mux_codes = '{MUX_TRISTATE, MUX_N_DIV, MUX_HIGH, MUX_R_DIV, MUX_OD_LOCK, MUX_LOW};
    mux_exp   = '{1'b0, n_div_mon, 1'b1, r_div_mon, 1'b0, 1'b0};
  end

  scld_host_model u_host (.sclk, .sdata, .sle);

  scld_core DUT (.clk, .rst, .sclk, .sdata, .sle, .cmp_cycle, .err_below_15, .err_above_30,
    .n_div_mon, .r_div_mon, .counters_reset, .cp_tristate, .power_down, .phase_polarity,
    .cp_current, .cp_gain_16x, .ref_doubler, .ref_both_edges, .ref_div, .prescaler_89,
    .int_value, .fraction_value, .interpolator_modulus, .dither_en, .cp_low_noise_bias,
    .lock_detect, .muxed_test_output, .muxed_test_output_oe_n, .fl_state);

  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  function automatic logic [11:0] seen(input scld_sig_t id);
    case (id)
      S_CRST: return 12'(counters_reset);
      S_TRI:  return 12'(cp_tristate);
      S_PD:   return 12'(power_down);
      S_POL:  return 12'(phase_polarity);
      S_CPI:  return 12'(cp_current);
      S_G16:  return 12'(cp_gain_16x);
      S_DBL:  return 12'(ref_doubler);
      S_EDGE: return 12'(ref_both_edges);
      S_RDIV: return 12'(ref_div);
      S_MOD:  return interpolator_modulus;
      S_INT:  return 12'(int_value);
      S_FRACTION_VALUE: return fraction_value;
      S_DITH: return 12'(dither_en);
      S_BIAS: return 12'(cp_low_noise_bias);
      S_LOCK: return 12'(lock_detect);
      S_MUX:  return 12'(muxed_test_output);
      S_OEN:  return 12'(muxed_test_output_oe_n);
      S_PRE:  return 12'(prescaler_89);
      default: return 12'(fl_state);
    endcase
  endfunction : seen

  task automatic check(input logic [11:0] s, input logic [11:0] e, input scld_sig_t id);
    tests_run++;
    if (s !== e) begin
      num_errors++;
      $display("[ERR] %0t signal %0d seen %h expected %h", $time, id, s, e);
    end
  endtask : check

  // monitor: compare every queued note when outputs have settled
  always @(settle_ev) begin
    while (notes.size() > 0) begin
      check(seen(notes[0].id), notes[0].exp, notes[0].id);
      void'(notes.pop_front());
    end
  end

  task automatic note(input scld_sig_t id, input logic [11:0] exp);
    notes.push_back('{id, exp});
  endtask : note

  task automatic settle();
    -> settle_ev;
    @(posedge clk);
    #1;
  endtask : settle

  task automatic wr(input scld_word_t w);
    u_host.send(w);
    repeat (8) @(posedge clk);
    #1;
  endtask : wr

  task automatic pulses(input int n, input logic good, input logic bad);
    repeat (n) begin
      cmp_cycle    = 1'b1;
      err_below_15 = good;
      err_above_30 = bad;
      @(posedge clk);
      #1;
      cmp_cycle    = 1'b0;
      err_below_15 = 1'($urandom);
      err_above_30 = 1'($urandom);
      @(posedge clk);
      #1;
    end
  endtask : pulses

  function automatic scld_word_t ref_w(input logic ld, input logic [2:0] mux);
    return {ld, mux, 1'b0, pre, rd, m1, SEL_REF};
  endfunction : ref_w

  // control fields: doubler, current, polarity, precision, down, float, reset
  task automatic ctl_chk(input logic [9:0] f);
    wr({12'h000, f, SEL_CTRL});
    note(S_CRST, 12'(f[0] | f[2]));
    note(S_TRI, 12'(f[1] | f[2]));
    note(S_PD, 12'(f[2]));
    note(S_POL, 12'(f[4]));
    note(S_CPI, 12'(f[8:5]));
    note(S_DBL, 12'(f[9]));
    note(S_EDGE, 12'(f[9]));
    settle();
  endtask : ctl_chk

  task automatic complete_run();
    if (num_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : complete_run

  initial begin
    #100us;
    num_errors++;
    complete_run();
  end

  initial begin
    rst = 1'b1;
    {cmp_cycle, err_below_15, err_above_30, n_div_mon, r_div_mon} = 5'h00;
    num_errors = 0;
    tests_run = 0;
    pre = 1'b0;
    void'($urandom(32'he6b8ca81));
    rd = 4'($urandom_range(15, 1));
    m1 = 12'($urandom_range(4095, 50));
    iv = 9'($urandom_range(511, 91));
    fr = 12'($urandom_range(int'(m1) - 1, 0));
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    note(S_MOD, 12'h000);
    note(S_RDIV, 12'h001);
    note(S_OEN, 12'h001);
    settle();
    // power-up order with two noise modes
    wr(24'h000003);
    note(S_DITH, 12'h001);
    note(S_BIAS, 12'h000);
    settle();
    wr(24'h0003c7);
    note(S_DITH, 12'h000);
    note(S_BIAS, 12'h001);
    settle();
    ctl_chk(10'($urandom) & 10'h3f3 | 10'h001);
    wr(ref_w(1'b0, MUX_TRISTATE));
    note(S_MOD, 12'h000);
    note(S_RDIV, 12'(rd));
    settle();
    wr({1'b0, iv, fr, SEL_INT});
    note(S_MOD, m1);
    note(S_INT, 12'(iv));
    note(S_FRACTION_VALUE, fr);
    settle();
    for (int i = 0; i < 3; i++) begin
      ctl_chk(10'($urandom) & 10'h3f2);
    end
    // fast lock with a slow host
    u_host.extra_ns = 20;
    wr({1'b1, MUX_FL_SW, 2'b00, rd, 12'h005, SEL_REF});
    note(S_MOD, m1);
    settle();
    wr(ref_w(1'b0, MUX_FL_SW));
    wr({1'b1, iv, fr, SEL_INT});
    u_host.extra_ns = 0;
    note(S_FL, 12'h001);
    note(S_G16, 12'h001);
    note(S_OEN, 12'h000);
    note(S_MUX, 12'h000);
    settle();
    pulses(4, 1'b0, 1'b0);
    note(S_FL, 12'h001);
    settle();
    pulses(1, 1'b0, 1'b0);
    note(S_FL, 12'h000);
    note(S_G16, 12'h000);
    settle();
    note(S_OEN, 12'h001);
    settle();
    // lock detect, low then high precision
    wr(ref_w(1'b0, MUX_DIG_LOCK));
    pulses(23, 1'b1, 1'b0);
    note(S_LOCK, 12'h000);
    settle();
    pulses(1, 1'b1, 1'b0);
    note(S_LOCK, 12'h001);
    note(S_MUX, 12'h001);
    settle();
    pulses(5, 1'b0, 1'b0);
    note(S_LOCK, 12'h001);
    settle();
    pulses(1, 1'b0, 1'b1);
    note(S_LOCK, 12'h000);
    settle();
    ctl_chk(10'h008);
    pulses(39, 1'b1, 1'b0);
    note(S_LOCK, 12'h000);
    settle();
    pulses(1, 1'b1, 1'b0);
    note(S_LOCK, 12'h001);
    settle();
    wr({1'b0, iv, fr, SEL_INT});
    note(S_LOCK, 12'h000);
    settle();
    pulses(40, 1'b1, 1'b0);
    // power down keeps words and still takes serial words
    note(S_LOCK, 12'h000);
    ctl_chk(10'h00c);
    wr(24'h000007);
    note(S_DITH, 12'h000);
    note(S_BIAS, 12'h000);
    note(S_MOD, m1);
    note(S_INT, 12'(iv));
    settle();
    ctl_chk(10'h000);
    // output selector codes
    n_div_mon = 1'($urandom);
    r_div_mon = 1'($urandom);
    foreach (mux_codes[i]) begin
      pre = ~pre;
      wr(ref_w(1'b0, mux_codes[i]));
      note(S_OEN, 12'(mux_codes[i] == MUX_TRISTATE));
      note(S_PRE, 12'(pre));
      if (mux_codes[i] != MUX_TRISTATE) begin
        note(S_MUX, 12'(mux_exp[i]));
      end
      settle();
    end
    complete_run();
  end

endmodule : scld_core_bench

`default_nettype wire
